//--- hdl/ddr_burst2_port.sv
// Purpose: device side of a two-word burst double-data-rate SRAM port
// Assumes: link clocks far slower than clk; controller keeps its side
// Notes: every pin passes three flops before use
module ddr_burst2_port
   import ddr_burst_pkg::*;
#(
   parameter int DATA_W = ddr_burst_pkg::DATA_W_DEF,
   parameter int ADDR_W = ddr_burst_pkg::ADDR_W_DEF
) (
   input wire logic clk, // core clock, 20 MHz
   input wire logic rst_n, // synchronous reset, active low
   input wire logic kIn, // true input clock
   input wire logic kNIn, // complement input clock
   input wire logic cIn, // true output clock
   input wire logic cNIn, // complement output clock
   input wire logic outClkSupplied, // high when output clocks present
   input wire logic latencySelectPin, // high: 1.5 cycle, low: 1 cycle
   input wire logic loadN, // command valid, active low
   input wire logic readNotWrite, // high read, low write
   input wire logic [ADDR_W-1:0] addrIn, // burst address
   input wire logic [DATA_W-1:0] dataIn, // data bus input level
   output logic [DATA_W-1:0] dataOut, // data bus drive value
   output logic dataOe, // data bus drive enable
   output logic echoStrobe, // echo clock, true
   output logic echoStrobeN // echo clock, complement
);
   import ddr_burst_pkg::*;

   localparam int PIN_W = PIN_ADDR + ADDR_W + DATA_W; // sampled pins
   localparam int PIN_DATA = PIN_ADDR + ADDR_W; // data field position

   // beat address at this port's width: low bit flipped for beat one
   function automatic logic [ADDR_W-1:0] beatAddr(
         input logic [ADDR_W-1:0] base, input logic beat);
      return {base[ADDR_W-1:1], base[0] ^ beat};
   endfunction

   // synchroniser stages and filtered pin levels
   logic [PIN_W-1:0] pinRaw, syncA, syncB, syncC, pinStab, pinPrev;
   logic [PIN_W-1:0] next_pinStab;
   logic kRise, kNRise, kFall, launchRise, launchNRise, launchEdge;
   logic [ADDR_W-1:0] pinAddr; // filtered address
   logic [DATA_W-1:0] pinData; // filtered data bus
   // command and write state
   logic skip, next_skip; // next k rise is the burst's busy edge
   logic capture; // command taken this cycle
   logic [1:0] wrStage, next_wrStage; // expected write word
   logic [ADDR_W-1:0] wrAddr, next_wrAddr; // write burst base
   logic pendValid, next_pendValid; // word waiting for buffer
   logic [ADDR_W-1:0] pendAddr, next_pendAddr; // its address
   logic [DATA_W-1:0] pendData, next_pendData; // its data
   // two-entry write buffer
   logic [ADDR_W-1:0] bufAddr [0:1]; // buffered addresses
   logic [DATA_W-1:0] bufData [0:1]; // buffered words
   logic [1:0] bufCnt, next_bufCnt; // occupancy
   logic bufWp, next_bufWp, bufRp, next_bufRp; // pointers
   logic bufInReady, bufOutValid, bufOutReady; // handshakes
   // read fetch and launch state
   fetch_t state, next_state; // fetch sequencer
   logic [ADDR_W-1:0] rdAddr, next_rdAddr; // read burst base
   logic [DATA_W-1:0] word0, next_word0, word1, next_word1; // read words
   logic [2:0] cnt, next_cnt, cntInc; // launch edges since capture
   logic [2:0] first; // launch edge of word 0
   logic [DATA_W-1:0] next_dataOut; // next bus value
   logic next_dataOe, next_echo, next_echoN; // next outputs
   // array port
   logic memEn, memWe; // access controls
   logic [ADDR_W-1:0] memAddr; // access address
   logic [DATA_W-1:0] memWdata, memRdata; // access data

   assign pinRaw = {dataIn, addrIn, readNotWrite, loadN, outClkSupplied,
                    latencySelectPin, cNIn, cIn, kNIn, kIn};

   // filtered level follows once the second and third stages agree
   always_comb begin
      next_pinStab = (syncB & ~(syncB ^ syncC)) | (pinStab & (syncB ^ syncC));
   end

   // three-flop synchroniser and filtered levels
   always_ff @(posedge clk) begin
      syncA <= pinRaw;
      syncB <= syncA;
      syncC <= syncB;
      if (!rst_n) begin
         // start from the pin levels so no false edge follows reset
         pinStab <= syncC;
         pinPrev <= syncC;
      end else begin
         pinStab <= next_pinStab;
         pinPrev <= pinStab;
      end
   end

   // rising edges only; the falling edge kFall feeds no logic and no check
   assign kRise = pinStab[PIN_K] & ~pinPrev[PIN_K];
   assign kNRise = pinStab[PIN_KN] & ~pinPrev[PIN_KN];
   assign kFall = ~pinStab[PIN_K] & pinPrev[PIN_K];
   // launch clock pair: output clocks if supplied, else input clocks
   assign launchRise = pinStab[PIN_OSEL] ?
                       (pinStab[PIN_C] & ~pinPrev[PIN_C]) : kRise;
   assign launchNRise = pinStab[PIN_OSEL] ?
                        (pinStab[PIN_CN] & ~pinPrev[PIN_CN]) : kNRise;
   assign launchEdge = launchRise | launchNRise;
   assign pinAddr = pinStab[PIN_ADDR +: ADDR_W];
   assign pinData = pinStab[PIN_DATA +: DATA_W];
   // command on a non-busy k rise only
   assign capture = kRise & ~skip & ~pinStab[PIN_LDN];

   // buffer handshakes: drain stalls while a read owns the port
   assign bufInReady = (bufCnt != 2'h2);
   assign bufOutValid = (bufCnt != 2'h0);
   assign bufOutReady = (state == FETCH_IDLE);

   // command, write-word and pending-slot next state
   always_comb begin
      next_skip = skip;
      next_wrStage = wrStage;
      next_wrAddr = wrAddr;
      next_pendValid = pendValid;
      next_pendAddr = pendAddr;
      next_pendData = pendData;
      // pending word moves into the buffer when it has room
      if (pendValid && bufInReady) begin
         next_pendValid = 1'b0;
      end
      if (kRise) begin
         next_skip = capture;
         if (wrStage == WR_WORD0) begin
            // first word on the true clock rise
            next_pendValid = 1'b1;
            next_pendAddr = beatAddr(wrAddr, 1'b0);
            next_pendData = pinData;
            next_wrStage = WR_WORD1;
         end
         if (capture && !pinStab[PIN_RWN]) begin
            next_wrStage = WR_WORD0; // write command
            next_wrAddr = pinAddr;
         end
      end else if (kNRise && wrStage == WR_WORD1) begin
         // second word on the complement rise
         next_pendValid = 1'b1;
         next_pendAddr = beatAddr(wrAddr, 1'b1);
         next_pendData = pinData;
         next_wrStage = WR_NONE;
      end
   end

   // write buffer pointers and occupancy
   always_comb begin
      next_bufWp = bufWp;
      next_bufRp = bufRp;
      next_bufCnt = bufCnt;
      if (pendValid && bufInReady) begin
         next_bufWp = ~bufWp;
      end
      if (bufOutValid && bufOutReady) begin
         next_bufRp = ~bufRp;
      end
      if ((pendValid && bufInReady) && !(bufOutValid && bufOutReady)) begin
         next_bufCnt = bufCnt + 2'h1;
      end else if (!(pendValid && bufInReady) &&
                   (bufOutValid && bufOutReady)) begin
         next_bufCnt = bufCnt - 2'h1;
      end
   end

   // array port: read fetch first, else self-timed write drain
   always_comb begin
      memEn = 1'b0;
      memWe = 1'b0;
      memAddr = bufAddr[bufRp];
      memWdata = bufData[bufRp];
      if (state == FETCH_W0) begin
         memEn = 1'b1;
         memAddr = beatAddr(rdAddr, 1'b0);
      end else if (state == FETCH_W1) begin
         memEn = 1'b1;
         memAddr = beatAddr(rdAddr, 1'b1);
      end else if (bufOutValid) begin
         memEn = 1'b1;
         memWe = 1'b1;
      end
   end

   // fetch sequencer next state
   always_comb begin
      next_state = state;
      next_rdAddr = rdAddr;
      next_word0 = word0;
      next_word1 = word1;
      case (state)
         FETCH_IDLE: begin
            if (capture && pinStab[PIN_RWN]) begin
               next_rdAddr = pinAddr;
               next_state = FETCH_W0;
            end
         end
         FETCH_W0: next_state = FETCH_W1;
         FETCH_W1: begin
            next_word0 = memRdata;
            next_state = FETCH_LAST;
         end
         FETCH_LAST: begin
            next_word1 = memRdata;
            next_state = FETCH_IDLE;
         end
         default: next_state = FETCH_IDLE;
      endcase
   end

   // launch: count launch edges since capture, drive words in turn
   assign first = pinStab[PIN_LAT] ? FIRST_SLOW : FIRST_FAST;
   assign cntInc = (cnt == CNT_IDLE) ? CNT_IDLE : cnt + 3'h1;
   always_comb begin
      next_cnt = cnt;
      next_dataOut = dataOut;
      next_dataOe = dataOe;
      if (launchEdge) begin
         next_cnt = cntInc;
         if (cntInc == first) begin
            next_dataOut = word0;
            next_dataOe = 1'b1;
         end else if (cntInc == first + 3'h1) begin
            next_dataOut = word1;
            next_dataOe = 1'b1;
         end else begin
            next_dataOe = 1'b0;
         end
      end
      if (capture && pinStab[PIN_RWN]) begin
         next_cnt = 3'h0;
      end
      // echoes follow the launch clock levels
      next_echo = pinStab[PIN_OSEL] ? pinStab[PIN_C] : pinStab[PIN_K];
      next_echoN = pinStab[PIN_OSEL] ? pinStab[PIN_CN] : pinStab[PIN_KN];
   end

   // register all control state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         skip <= 1'b0;
         wrStage <= WR_NONE;
         wrAddr <= '0;
         pendValid <= 1'b0;
         pendAddr <= '0;
         pendData <= '0;
         bufCnt <= 2'h0;
         bufWp <= 1'b0;
         bufRp <= 1'b0;
         state <= FETCH_IDLE;
         rdAddr <= '0;
         word0 <= '0;
         word1 <= '0;
         cnt <= CNT_IDLE;
         dataOut <= '0;
         dataOe <= 1'b0;
         echoStrobe <= 1'b0;
         echoStrobeN <= 1'b0;
      end else begin
         skip <= next_skip;
         wrStage <= next_wrStage;
         wrAddr <= next_wrAddr;
         pendValid <= next_pendValid;
         pendAddr <= next_pendAddr;
         pendData <= next_pendData;
         bufCnt <= next_bufCnt;
         bufWp <= next_bufWp;
         bufRp <= next_bufRp;
         state <= next_state;
         rdAddr <= next_rdAddr;
         word0 <= next_word0;
         word1 <= next_word1;
         cnt <= next_cnt;
         dataOut <= next_dataOut;
         dataOe <= next_dataOe;
         echoStrobe <= next_echo;
         echoStrobeN <= next_echoN;
      end
   end

   // buffer storage, written only when the push is accepted
   always_ff @(posedge clk) begin
      if (pendValid && bufInReady) begin
         bufAddr[bufWp] <= pendAddr;
         bufData[bufWp] <= pendData;
      end
   end

   burst_sram_array #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_array (
      .clk(clk),
      .en(memEn),
      .we(memWe),
      .addr(memAddr),
      .wdata(memWdata),
      .rdata(memRdata)
   );

   // checks
   sequence s_fetch;
      state == FETCH_W0 ##1 state == FETCH_W1 ##1 state == FETCH_LAST;
   endsequence
   sequence s_burst_addr;
      memAddr == beatAddr(rdAddr, 1'b0) ##1
         memAddr == beatAddr(rdAddr, 1'b1);
   endsequence
   property p_alt_edge;
      @(posedge clk) disable iff (!rst_n) (kRise && skip) |-> !capture;
   endproperty
   a_alt_edge: assert property (p_alt_edge) else $error("busy edge took command");
   property p_word1_wr;
      @(posedge clk) disable iff (!rst_n)
         (kNRise && wrStage == WR_WORD1) |=>
            pendValid && pendAddr == beatAddr(wrAddr, 1'b1);
   endproperty
   a_word1_wr: assert property (p_word1_wr) else $error("second write word lost");
   property p_fetch;
      @(posedge clk) disable iff (!rst_n)
         (capture && pinStab[PIN_RWN] && state == FETCH_IDLE) |=> s_fetch;
   endproperty
   a_fetch: assert property (p_fetch) else $error("read fetch out of step");
   property p_burst;
      @(posedge clk) disable iff (!rst_n) (state == FETCH_W0) |-> s_burst_addr;
   endproperty
   a_burst: assert property (p_burst) else $error("burst order wrong");
   property p_first_word;
      @(posedge clk) disable iff (!rst_n)
         (launchEdge && cntInc == first && !(capture && pinStab[PIN_RWN]))
            |=> dataOe && dataOut == $past(word0) ##1 dataOe;
   endproperty
   a_first_word: assert property (p_first_word) else $error("first read word late");
   property p_oe_rise;
      @(posedge clk) disable iff (!rst_n) $rose(dataOe) |-> $past(launchEdge);
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("bus driven off edge");
   property p_no_fall;
      @(posedge clk) disable iff (!rst_n)
         (!kRise && !kNRise) |=> $stable(wrStage) && $stable(skip);
   endproperty
   a_no_fall: assert property (p_no_fall) else $error("falling edge acted");
   property p_drain;
      @(posedge clk) disable iff (!rst_n)
         (bufOutValid && state == FETCH_IDLE) |=> bufCnt != $past(bufCnt)
            || pendValid != $past(pendValid) || $past(pendValid);
   endproperty
   a_drain: assert property (p_drain) else $error("write buffer stuck");
   property p_lat_fast;
      @(posedge clk) disable iff (!rst_n)
         (!pinStab[PIN_LAT] && launchEdge && cnt == 3'h1 &&
            !(capture && pinStab[PIN_RWN]))
            |=> dataOe && dataOut == $past(word0);
   endproperty
   a_lat_fast: assert property (p_lat_fast) else $error("fast latency not used");
endmodule

//--- pkg/ddr_burst_pkg.sv
// Purpose: shared constants and types of the two-word burst SRAM port
// Assumes: all link pins are sampled by the 20 MHz core clock
// Notes: pin vector positions describe the packed sampled-pin bus
package ddr_burst_pkg;
   // documented widths (narrow configuration) and depth
   localparam int DATA_W_DEF = 18;
   localparam int ADDR_W_DEF = 21;
   // core clock period, ns
   localparam int CLK_PERIOD_NS = 50;
   // positions inside the packed pin vector
   localparam int PIN_K = 0;
   localparam int PIN_KN = 1;
   localparam int PIN_C = 2;
   localparam int PIN_CN = 3;
   localparam int PIN_LAT = 4;
   localparam int PIN_OSEL = 5;
   localparam int PIN_LDN = 6;
   localparam int PIN_RWN = 7;
   localparam int PIN_ADDR = 8;
   // launch edge counter: idle value and first-word edge per latency
   localparam logic [2:0] CNT_IDLE = 3'h7;
   localparam logic [2:0] FIRST_SLOW = 3'h3;
   localparam logic [2:0] FIRST_FAST = 3'h2;
   // write data stage after a write command
   localparam logic [1:0] WR_NONE = 2'h0;
   localparam logic [1:0] WR_WORD0 = 2'h1;
   localparam logic [1:0] WR_WORD1 = 2'h2;
   // read fetch sequencer
   typedef enum logic [3:0] {
      FETCH_IDLE = 4'b0001,
      FETCH_W0 = 4'b0010,
      FETCH_W1 = 4'b0100,
      FETCH_LAST = 4'b1000
   } fetch_t;
   // address of beat n of a burst: low bit flipped for the second beat
   function automatic logic [ADDR_W_DEF-1:0] burstAddr(
         input logic [ADDR_W_DEF-1:0] base, input logic beat);
      burstAddr = {base[ADDR_W_DEF-1:1], base[0] ^ beat};
   endfunction
endpackage

//--- hdl/burst_sram_array.sv
// Purpose: single-port storage array with registered read data
// Assumes: one access per clock, write wins the port when we is high
// Notes: read data updates only on a read enable
module burst_sram_array #(
   parameter int DATA_W = 18,
   parameter int ADDR_W = 21
) (
   input wire logic clk, // core clock
   input wire logic en, // access enable
   input wire logic we, // write when high, read when low
   input wire logic [ADDR_W-1:0] addr, // word address
   input wire logic [DATA_W-1:0] wdata, // write word
   output logic [DATA_W-1:0] rdata // registered read word
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // storage words

   // one access per cycle, read data registered
   always_ff @(posedge clk) begin
      if (en && we) begin
         mem[addr] <= wdata;
      end
      if (en && !we) begin
         rdata <= mem[addr];
      end
   end
endmodule

//--- sim/ddr_ctrl_model.sv
// Purpose: memory controller model driving link clocks, commands, data
// Assumes: link cycle is eight core clocks, output pair lags by C_SKEW
// Notes: one command at a time through issue; returns its k rise tick
module ddr_ctrl_model
   import ddr_burst_pkg::*;
#(
   parameter int DATA_W = 18,
   parameter int ADDR_W = 8,
   parameter int C_SKEW = 2
) (
   input wire logic clk, // core clock
   input wire logic rst_n, // reset, active low
   output logic kIn, // true input clock
   output logic kNIn, // complement input clock
   output logic cIn, // true output clock
   output logic cNIn, // complement output clock
   output logic loadN, // command valid, active low
   output logic readNotWrite, // high read
   output logic [ADDR_W-1:0] addrIn, // burst address
   output logic [DATA_W-1:0] ctrlData, // write word on the bus
   output logic ctrlOe, // high while we drive the bus
   output int tick // free core clock count
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] ph; // link phase
   logic [2:0] next_ph; // next link phase
   logic [2:0] cph; // output pair phase
   // input clocks hold k low and kN high while reset holds
   initial begin
      ph = 3'h4;
      tick = 0;
      loadN = 1'b1;
      readNotWrite = 1'b1;
      addrIn = '0;
      ctrlData = '0;
      ctrlOe = 1'b0;
   end
   // phase of both clock pairs
   always_comb begin
      next_ph = rst_n ? ph + 3'h1 : 3'h4;
      cph = next_ph - 3'(C_SKEW);
   end
   // rising edges only carry meaning, pairs are complementary
   always @(posedge clk) begin
      ph <= next_ph;
      tick <= tick + 1;
      kIn <= next_ph < 3'h4;
      kNIn <= next_ph >= 3'h4;
      cIn <= cph < 3'h4;
      cNIn <= cph >= 3'h4;
   end
   // command half a cycle before its k rise, held half a cycle after
   task issue(input logic rw, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1,
         input logic busyHold, output int t);
      @(posedge clk);
      while (ph !== 3'h3) @(posedge clk);
      t = tick + 4;
      loadN <= 1'b0;
      readNotWrite <= rw;
      addrIn <= a;
      repeat (8) @(posedge clk);
      loadN <= ~busyHold;
      addrIn <= ~a;
      if (!rw) begin
         // word per half cycle, bus released after the second
         ctrlOe <= 1'b1;
         ctrlData <= d0;
         repeat (6) @(posedge clk);
         ctrlData <= d1;
         fork
            begin
               repeat (4) @(posedge clk);
               ctrlOe <= 1'b0;
            end
         join_none
      end else if (busyHold) begin
         repeat (8) @(posedge clk);
         loadN <= 1'b1;
      end
   endtask
endmodule

//--- sim/ddr_burst2_port_tb_top.sv
// Purpose: self-checking bench of the burst port against a queue model
// Assumes: outputs settle within six clocks of a launch edge
// Notes: all four latency and launch clock straps are visited
module ddr_burst2_port_tb_top;
   import ddr_burst_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DW = 18; // word width
   localparam int AW = 8; // shortened address
   localparam int LIMIT = 6000; // cycle ceiling
   typedef struct {
      int t;
      logic oe;
      logic [DW-1:0] d;
      logic [1:0] mb;
   } exp_t;
   logic clk = 1'b0; // core clock
   logic rst_n = 1'b0; // reset, active low
   logic kIn, kNIn, cIn, cNIn; // clock pairs
   logic outClkSupplied = 1'b0; // launch on output pair
   logic latencySelectPin = 1'b1; // slow latency
   logic loadN, readNotWrite; // command pins
   logic [AW-1:0] addrIn; // address pins
   logic [DW-1:0] dataIn, dataOut, ctrlData; // bus views
   logic dataOe, ctrlOe; // bus drive enables
   logic echoStrobe, echoStrobeN; // echo clocks
   logic [DW-1:0] lastDrv = '0; // last driven bus value
   int tick; // model clock count
   int bad_count = 0; // mismatches
   int compares = 0; // comparisons
   logic [31:0] seed = 32'h000109d7; // xorshift state
   logic [DW-1:0] mem [int]; // reference array
   exp_t q[$]; // pending output checks
   always #25 clk = ~clk;
   // floating bus shows the inverse of its last driven value
   assign dataIn = dataOe ? dataOut : (ctrlOe ? ctrlData : ~lastDrv);
   always @(posedge clk) begin
      if (dataOe) lastDrv <= dataOut;
      else if (ctrlOe) lastDrv <= ctrlData;
   end
   ddr_burst2_port #(.DATA_W(DW), .ADDR_W(AW)) dut_u (
      .clk(clk), .rst_n(rst_n), .kIn(kIn), .kNIn(kNIn), .cIn(cIn),
      .cNIn(cNIn), .outClkSupplied(outClkSupplied),
      .latencySelectPin(latencySelectPin), .loadN(loadN),
      .readNotWrite(readNotWrite), .addrIn(addrIn), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe), .echoStrobe(echoStrobe),
      .echoStrobeN(echoStrobeN));
   ddr_ctrl_model #(.DATA_W(DW), .ADDR_W(AW), .C_SKEW(2)) ctrl_u (
      .clk(clk), .rst_n(rst_n), .kIn(kIn), .kNIn(kNIn), .cIn(cIn),
      .cNIn(cNIn), .loadN(loadN), .readNotWrite(readNotWrite),
      .addrIn(addrIn), .ctrlData(ctrlData), .ctrlOe(ctrlOe),
      .tick(tick));
   // fixed-seed random source
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task end_sim();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask
   // one expected output view, six clocks after launch edge e
   task push(input int t0, input int e, input logic oe,
         input logic [DW-1:0] d);
      exp_t x;
      // output pair: first counted edge is the lagged true rise
      x.t = t0 + 4 * e - (outClkSupplied ? 2 : 0) + 6;
      x.oe = oe;
      x.d = d;
      x.mb = (e[0] ^ outClkSupplied) ? 2'b01 : 2'b10;
      q.push_back(x);
   endtask
   task wr(input logic [AW-1:0] a);
      logic [31:0] r0, r1;
      int t0;
      exp_t x;
      r0 = xs();
      r1 = xs();
      ctrl_u.issue(1'b0, a, r0[DW-1:0], r1[DW-1:0], 1'b0, t0);
      mem[int'(a)] = r0[DW-1:0];
      mem[int'(a ^ 8'h01)] = r1[DW-1:0];
      x.t = t0 + 11;
      x.oe = 1'b0;
      x.d = '0;
      x.mb = 2'b00;
      q.push_back(x);
   endtask
   task rd(input logic [AW-1:0] a, input logic busy, input logic idle);
      int t0, e0;
      ctrl_u.issue(1'b1, a, '0, '0, busy, t0);
      e0 = latencySelectPin ? 3 : 2;
      push(t0, e0, 1'b1, mem[int'(a)]);
      push(t0, e0 + 1, 1'b1, mem[int'(a ^ 8'h01)]);
      if (idle) push(t0, e0 + 2, 1'b0, '0);
   endtask
   // compare due views, cut a hang short
   always @(posedge clk) begin
      if (tick > LIMIT) begin
         bad_count++;
         $display("MISMATCH t=%0t run too long", $time);
         end_sim();
      end
      for (int i = q.size() - 1; i >= 0; i--) begin
         if (q[i].t == tick) begin
            chk(dataOe === q[i].oe, "bus drive enable");
            if (q[i].oe) chk(dataOut === q[i].d, "read word");
            if (q[i].mb != 2'b00)
               chk({echoStrobe, echoStrobeN} === q[i].mb, "echo");
            q.delete(i);
         end
      end
   end
   // reset, then writes and reads under every strap setting
   initial begin
      logic [AW-1:0] bases[$];
      logic [31:0] r;
      repeat (11) @(posedge clk);
      chk(dataOe === 1'b0 && dataOut === '0, "reset bus");
      chk({echoStrobe, echoStrobeN} === 2'b00, "reset echo");
      @(posedge clk);
      rst_n <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         repeat (8) @(posedge clk);
         latencySelectPin <= ~m[0];
         outClkSupplied <= m[1];
         repeat (16) @(posedge clk);
         bases = {};
         for (int i = 0; i < 4; i++) begin
            r = xs();
            wr(r[AW-1:0]);
            bases.push_back(r[AW-1:0]);
         end
         repeat (16) @(posedge clk);
         foreach (bases[i]) rd(bases[i] ^ AW'(i % 2), 1'b0, i == 3);
         repeat (24) @(posedge clk);
         rd(bases[0], 1'b1, 1'b1);
         repeat (40) @(posedge clk);
      end
      chk(q.size() == 0, "checks left over");
      end_sim();
   end
endmodule
